// >>> design/pllcfg_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "pllcfg_regs.svh"
module pllcfg_top
   import pllcfg_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   // device pins
   input  wire logic        hard_reset_pin_n,
   input  wire logic        addr_select_hi,
   input  wire logic        addr_select_lo,
   // serial bus, open drain data
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   // loop filter and pump
   output logic      [2:0]  loop_cap_sel,
   output logic      [2:0]  loop_res_sel,
   output logic      [2:0]  pump_current_sel,
   // dividers
   output logic      [13:0] ref_divider_value,
   output logic      [9:0]  feedback_div_wide,
   output logic      [7:0]  feedback_div_narrow,
   // status routing
   output logic             stat_b_refclk_en,
   output logic             stat_b_refloss_en,
   output logic             stat_b_lock_en,
   output logic             stat_a_refclk_en,
   output logic             stat_a_refloss_en,
   output logic             stat_a_lock_en,
   // device control
   output logic             soft_hold_n,
   output logic             divider_align_n,
   output logic             vco_calibrate_en,
   output logic      [1:0]  prescaler_second_sel,
   output logic      [1:0]  prescaler_first_sel
);
   // synchronised pins
   logic scl_s, sda_s, hrst_s, ad_hi_s, ad_lo_s;
   // bus lines rest high, so their stages reset high
   // so no false start or edge follows reset
   pllcfg_sync #(.INIT(1'b1)) u_scl  (.core_clk(core_clk), .reset_n(reset_n), .async_in(scl_in),
                                      .sync_out(scl_s));
   pllcfg_sync #(.INIT(1'b1)) u_sda  (.core_clk(core_clk), .reset_n(reset_n), .async_in(sda_in),
                                      .sync_out(sda_s));
   pllcfg_sync #(.INIT(1'b0)) u_hrst (.core_clk(core_clk), .reset_n(reset_n),
                                      .async_in(hard_reset_pin_n), .sync_out(hrst_s));
   pllcfg_sync #(.INIT(1'b0)) u_adh  (.core_clk(core_clk), .reset_n(reset_n),
                                      .async_in(addr_select_hi), .sync_out(ad_hi_s));
   pllcfg_sync #(.INIT(1'b0)) u_adl  (.core_clk(core_clk), .reset_n(reset_n),
                                      .async_in(addr_select_lo), .sync_out(ad_lo_s));

   // state
   pllcfg_state_t state_r;          // transfer phase
   logic        scl_d_r, sda_d_r;   // previous samples
   logic [3:0]  bit_cnt_r;          // bit within byte, 8 is ack slot
   logic [7:0]  shift_r;            // incoming byte
   logic        byte_idx_r;         // which half of a pair
   logic        rw_r;               // read direction latched
   logic        ack_drive_r;        // pull data low for ack
   logic        tx_bit_r;           // read data bit on line
   logic        tx_en_r;            // driving read data
   logic [15:0] index_r;            // register index
   logic [15:0] wdata_r;            // write data high byte, low byte unused
   logic [15:0] rword_r;            // captured read word
   logic [1:0]  strap_r;            // address straps
   logic        strap_ok_r;         // straps captured
   logic [1:0]  strap_wait_r;       // settle count before strap capture
   logic        ack_due_r;          // this side owns the coming ack slot
   logic        wr_pulse_r;         // one cycle write strobe
   logic [15:0] loop_r, refdiv_r, fbdiv_r, ctrl_r;
   logic [15:0] rd_data;

   // bus events
   // slave taken off the bus while the hardware pin is low
   wire active    = hrst_s;
   // clock edges seen on the synchronised line
   wire scl_rise  = scl_s && !scl_d_r;
   wire scl_fall  = !scl_s && scl_d_r;
   // framing: data moves while the clock stays high
   wire start_ev  = scl_s && scl_d_r && sda_d_r && !sda_s;
   wire stop_ev   = scl_s && scl_d_r && !sda_d_r && sda_s;
   wire [7:0] byte_in = {shift_r[6:0], sda_s};
   wire data_bit  = scl_rise && (bit_cnt_r < 4'd8);
   wire last_bit  = data_bit && (bit_cnt_r == 4'd7);
   wire ack_bit   = scl_rise && (bit_cnt_r == 4'd8);
   // bit of the read byte to put out, first one while the count still shows the ack slot
   wire [2:0] tx_pos = (bit_cnt_r == 4'd9) ? 3'h7 : ~bit_cnt_r[2:0];
   wire addr_hit  = (byte_in[7:3] == `PLLCFG_DEV_ADDR_HI) && (byte_in[2:1] == strap_r);

   // straps taken once after reset release
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         strap_r      <= 2'b00;
         strap_ok_r   <= 1'b0;
         strap_wait_r <= 2'b00;
      end else if (!strap_ok_r) begin
         // synchroniser outputs still show their reset level at first
         if (strap_wait_r == `PLLCFG_STRAP_WAIT) begin
            strap_r    <= {ad_hi_s, ad_lo_s};
            strap_ok_r <= 1'b1;
         end else begin
            strap_wait_r <= strap_wait_r + 2'h1;
         end
      end
   end

   // edge history
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
      end
   end

   // byte shifter and bit counter
   always_ff @(posedge core_clk) begin
      if (!reset_n || !active || start_ev) begin
         // a start always realigns the byte
         bit_cnt_r <= 4'd0;
         shift_r   <= 8'h00;
      end else if (data_bit) begin
         // data bit taken on the rising clock
         shift_r   <= byte_in;
         bit_cnt_r <= bit_cnt_r + 4'd1;
      end else if (scl_fall && bit_cnt_r == 4'd9) begin
         // ack slot over, next byte begins
         bit_cnt_r <= 4'd0;
      end else if (ack_bit) begin
         // ninth clock seen, wait for its falling edge
         bit_cnt_r <= 4'd9;
      end
   end

   // transfer sequencing
   always_ff @(posedge core_clk) begin
      if (!reset_n || !active) begin
         state_r    <= PLLCFG_IDLE;
         byte_idx_r <= 1'b0;
         rw_r       <= 1'b0;
         index_r    <= 16'h0000;
         wdata_r    <= 16'h0000;
         rword_r    <= 16'h0000;
         wr_pulse_r <= 1'b0;
         ack_due_r  <= 1'b0;
      end else begin
         wr_pulse_r <= 1'b0;
         if (start_ev) begin
            state_r <= PLLCFG_DEVADDR;                           // repeated start too
         end else if (stop_ev) begin
            state_r <= PLLCFG_IDLE;
         end else if (last_bit) begin
            // this side acknowledges a matching address and the two index and two data bytes of a write
            ack_due_r <= ((state_r == PLLCFG_DEVADDR) && addr_hit) ||
                         (state_r == PLLCFG_REGADDR) || (state_r == PLLCFG_WDATA);
            unique case (state_r)
               PLLCFG_DEVADDR: begin
                  // seven bit address and direction bit
                  byte_idx_r <= 1'b0;
                  rw_r       <= byte_in[0];
                  if (!addr_hit) begin
                     // not ours: stay off the line until the next start
                     state_r <= PLLCFG_IGNORE;
                  end else if (byte_in[0]) begin
                     state_r <= PLLCFG_RDATA;
                     rword_r <= rd_data;
                  end else begin
                     state_r <= PLLCFG_REGADDR;
                  end
               end
               PLLCFG_REGADDR: begin
                  // index arrives high byte first
                  if (!byte_idx_r) begin
                     index_r[15:8] <= byte_in;
                  end else begin
                     index_r[7:0] <= byte_in;
                     state_r      <= PLLCFG_WDATA;
                  end
                  byte_idx_r <= !byte_idx_r;
               end
               PLLCFG_WDATA: begin
                  // data high byte, then the low byte commits
                  if (!byte_idx_r) begin
                     wdata_r[15:8] <= byte_in;
                  end else begin
                     wr_pulse_r <= 1'b1;
                     state_r    <= PLLCFG_IGNORE;
                  end
                  byte_idx_r <= !byte_idx_r;
               end
               PLLCFG_RDATA, PLLCFG_IDLE, PLLCFG_IGNORE: begin
                  // nothing to take from the line
               end
            endcase
         end else if (ack_bit && state_r == PLLCFG_RDATA && !ack_due_r) begin
            // master answer after a read byte; the address slot is our own
            if (sda_s || byte_idx_r) begin
               state_r <= PLLCFG_IGNORE;
            end
            byte_idx_r <= 1'b1;
         end
      end
   end

   // ack and read data drive, taken up only on a falling clock, dropped at once on framing or reset
   always_ff @(posedge core_clk) begin
      if (!reset_n || !active || start_ev || stop_ev) begin
         // let the line go at once on framing or reset
         ack_drive_r <= 1'b0;
         tx_en_r     <= 1'b0;
         tx_bit_r    <= 1'b1;
      end else if (scl_fall) begin
         // each falling clock releases the line unless an ack or a read data bit is set below
         ack_drive_r <= 1'b0;
         tx_en_r     <= 1'b0;
         if (bit_cnt_r == 4'd8) begin
            // ninth clock: pull low only where this side acknowledges
            ack_drive_r <= ack_due_r;
         end else if (state_r == PLLCFG_RDATA && rw_r) begin
            // read word goes out high byte first, msb first
            tx_en_r  <= 1'b1;
            tx_bit_r <= rword_r[{~byte_idx_r, tx_pos}];
         end
      end
   end

   // open drain: drive only low
   assign sda_out = 1'b0;
   // either an ack or a zero data bit pulls the line
   assign sda_oe  = ack_drive_r || (tx_en_r && !tx_bit_r);

   // register storage
   pllcfg_regfile u_regs (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .wr_en    (wr_pulse_r),
      .wr_addr  (index_r),
      .wr_data  ({wdata_r[15:8], shift_r}),
      .rd_addr  (index_r),
      .rd_data  (rd_data),
      .loop_r   (loop_r),
      .refdiv_r (refdiv_r),
      .fbdiv_r  (fbdiv_r),
      .ctrl_r   (ctrl_r)
   );

   // field outputs
   assign loop_cap_sel         = loop_r[`PLLCFG_CAP_MSB:`PLLCFG_CAP_LSB];
   assign loop_res_sel         = loop_r[`PLLCFG_RES_MSB:`PLLCFG_RES_LSB];
   assign pump_current_sel     = loop_r[`PLLCFG_ICP_MSB:`PLLCFG_ICP_LSB];
   // divider fields
   assign ref_divider_value    = refdiv_r[`PLLCFG_REFDIV_MSB:`PLLCFG_REFDIV_LSB];
   assign feedback_div_wide    = {refdiv_r[1:0], fbdiv_r[15:8]};
   assign feedback_div_narrow  = fbdiv_r[7:0];
   // second status pin sources
   assign stat_b_refclk_en     = ctrl_r[`PLLCFG_STB_REFCLK];
   assign stat_b_refloss_en    = ctrl_r[`PLLCFG_STB_LOSS];
   assign stat_b_lock_en       = ctrl_r[`PLLCFG_STB_LOCK];
   // first status pin sources
   assign stat_a_refclk_en     = ctrl_r[`PLLCFG_STA_REFCLK];
   assign stat_a_refloss_en    = ctrl_r[`PLLCFG_STA_LOSS];
   assign stat_a_lock_en       = ctrl_r[`PLLCFG_STA_LOCK];
   // device hold, divider alignment and calibration
   assign soft_hold_n          = ctrl_r[`PLLCFG_HOLD_N];
   assign divider_align_n      = ctrl_r[`PLLCFG_ALIGN_N];
   assign vco_calibrate_en     = ctrl_r[`PLLCFG_CAL_EN];
   // prescaler selections
   assign prescaler_second_sel = ctrl_r[3:2];
   assign prescaler_first_sel  = ctrl_r[1:0];
endmodule : pllcfg_top
`default_nettype wire

// >>> design/pllcfg_regs.svh
`ifndef PLLCFG_REGS_SVH
`define PLLCFG_REGS_SVH
// register indices
`define PLLCFG_REG_LOOP        16'h0000
`define PLLCFG_REG_REFDIV      16'h0001
`define PLLCFG_REG_FBDIV       16'h0002
`define PLLCFG_REG_CTRL        16'h0003
// writable bit masks (reserved bits clear)
`define PLLCFG_MASK_LOOP       16'h03FE
`define PLLCFG_MASK_REFDIV     16'hFFFF
`define PLLCFG_MASK_FBDIV      16'hFFFF
`define PLLCFG_MASK_CTRL       16'h1FFF
// reset values
`define PLLCFG_RST_LOOP        16'h0000
`define PLLCFG_RST_REFDIV      16'h0000
`define PLLCFG_RST_FBDIV       16'h0000
`define PLLCFG_RST_CTRL        16'h0000
// fixed upper address bits
`define PLLCFG_DEV_ADDR_HI     5'h15
// clocks to wait after reset before sampling the straps
`define PLLCFG_STRAP_WAIT      2'h2
// field positions
`define PLLCFG_CAP_MSB         9
`define PLLCFG_CAP_LSB         7
`define PLLCFG_RES_MSB         6
`define PLLCFG_RES_LSB         4
`define PLLCFG_ICP_MSB         3
`define PLLCFG_ICP_LSB         1
`define PLLCFG_REFDIV_MSB      15
`define PLLCFG_REFDIV_LSB      2
`define PLLCFG_STB_REFCLK      12
`define PLLCFG_STB_LOSS        11
`define PLLCFG_STB_LOCK        10
`define PLLCFG_STA_REFCLK      9
`define PLLCFG_STA_LOSS        8
`define PLLCFG_STA_LOCK        7
`define PLLCFG_HOLD_N          6
`define PLLCFG_ALIGN_N         5
`define PLLCFG_CAL_EN          4
`endif

// >>> design/pllcfg_pkg.sv
package pllcfg_pkg;
   // serial slave phases
   typedef enum logic [2:0] {
      PLLCFG_IDLE,
      PLLCFG_DEVADDR,
      PLLCFG_REGADDR,
      PLLCFG_WDATA,
      PLLCFG_RDATA,
      PLLCFG_IGNORE
   } pllcfg_state_t;
endpackage : pllcfg_pkg

// >>> design/pllcfg_sync.sv
`timescale 1ns/100ps
`default_nettype none
// two flop synchroniser with a set reset value
module pllcfg_sync #(
   parameter logic INIT = 1'b1
) (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic reset_n,
   // level in and out
   input  wire logic async_in,
   output logic      sync_out
);
   logic meta_r;   // first stage, read only by second
   // two stage capture
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         meta_r   <= INIT;
         sync_out <= INIT;
      end else begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule : pllcfg_sync
`default_nettype wire

// >>> design/pllcfg_regfile.sv
`timescale 1ns/100ps
`default_nettype none
`include "pllcfg_regs.svh"
// four word configuration store
module pllcfg_regfile
   import pllcfg_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   // write port
   input  wire logic        wr_en,
   input  wire logic [15:0] wr_addr,
   input  wire logic [15:0] wr_data,
   // read port
   input  wire logic [15:0] rd_addr,
   output logic      [15:0] rd_data,
   // stored words
   output logic      [15:0] loop_r,
   output logic      [15:0] refdiv_r,
   output logic      [15:0] fbdiv_r,
   output logic      [15:0] ctrl_r
);
   // write decode
   wire sel_loop   = wr_en && (wr_addr == `PLLCFG_REG_LOOP);
   wire sel_refdiv = wr_en && (wr_addr == `PLLCFG_REG_REFDIV);
   wire sel_fbdiv  = wr_en && (wr_addr == `PLLCFG_REG_FBDIV);
   wire sel_ctrl   = wr_en && (wr_addr == `PLLCFG_REG_CTRL);
   // bit 0 of loop word and reserved bits held at zero
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         loop_r   <= `PLLCFG_RST_LOOP;
         refdiv_r <= `PLLCFG_RST_REFDIV;
         fbdiv_r  <= `PLLCFG_RST_FBDIV;
         ctrl_r   <= `PLLCFG_RST_CTRL;
      end else begin
         if (sel_loop) loop_r <= wr_data & `PLLCFG_MASK_LOOP;
         if (sel_refdiv) refdiv_r <= wr_data & `PLLCFG_MASK_REFDIV;
         if (sel_fbdiv) fbdiv_r <= wr_data & `PLLCFG_MASK_FBDIV;
         if (sel_ctrl) ctrl_r <= wr_data & `PLLCFG_MASK_CTRL;
      end
   end
   // read select, unmapped reads as zero
   assign rd_data = (rd_addr == `PLLCFG_REG_LOOP)   ? loop_r   :
                    (rd_addr == `PLLCFG_REG_REFDIV) ? refdiv_r :
                    (rd_addr == `PLLCFG_REG_FBDIV)  ? fbdiv_r  :
                    (rd_addr == `PLLCFG_REG_CTRL)   ? ctrl_r   : 16'h0000;
endmodule : pllcfg_regfile
`default_nettype wire

// >>> bench/pllcfg_checker.sv
`timescale 1ns/100ps
`default_nettype none
// bus and register checks seen from the top ports
module pllcfg_checker (
   // clock and reset
   input wire logic        core_clk,
   input wire logic        reset_n,
   // device pins
   input wire logic        hard_reset_pin_n,
   input wire logic        scl_in,
   input wire logic        sda_in,
   input wire logic        sda_out,
   input wire logic        sda_oe,
   // a slice of the stored fields
   input wire logic [2:0]  loop_cap_sel,
   input wire logic [13:0] ref_divider_value,
   input wire logic [7:0]  feedback_div_narrow,
   input wire logic        soft_hold_n,
   input wire logic        divider_align_n
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   logic [24:0] cfg;  // watched part of the store
   assign cfg = {loop_cap_sel, ref_divider_value, feedback_div_narrow};
   // bus quiet with both lines high
   sequence bus_idle;
      (scl_in && sda_in)[*8];
   endsequence
   // hardware pin low long enough to pass the synchroniser
   sequence pin_held;
      (!hard_reset_pin_n)[*5];
   endsequence
   chk_oe_scl_low: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in))
      else $error("data pulled low while clock high");
   chk_oe_clk_high: assert property (scl_in[*6] |-> $stable(sda_oe))
      else $error("data line moved while clock high");
   chk_commit_scl: assert property ($changed(cfg) |-> scl_in && $past(scl_in, 2))
      else $error("register changed outside a clock high phase");
   chk_idle_store: assert property (bus_idle |=> $stable(cfg))
      else $error("register changed on an idle bus");
   chk_pin_silent: assert property (pin_held |-> !sda_oe)
      else $error("data driven while hardware reset pin low");
   chk_pin_keeps: assert property (pin_held |-> $stable(cfg))
      else $error("register changed while hardware reset pin low");
   chk_open_drain: assert property (sda_oe |-> sda_out == 1'b0)
      else $error("data line driven high");
   chk_reset_quiet: assert property ($rose(reset_n) |-> (!sda_oe)[*8])
      else $error("data driven just after reset");
   chk_reset_hold: assert property ($rose(reset_n) |-> !soft_hold_n && !divider_align_n)
      else $error("device not held after reset");
endmodule : pllcfg_checker
`default_nettype wire

// >>> bench/pllcfg_master.sv
`timescale 1ns/100ps
`default_nettype none
// serial bus master, changes lines on the falling core clock edge
module pllcfg_master (
   // clock
   input  wire logic core_clk,
   // bus
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda_drv
);
   int half = 10;  // core clocks per clock high phase, at least 8
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic hp;
      repeat (half) @(negedge core_clk);
   endtask : hp
   // one clock pulse: data set while low, sampled at end of high
   task automatic bitx(input logic b, output logic s);
      repeat (2) @(negedge core_clk);
      sda_drv = b;
      hp();
      scl = 1'b1;
      hp();
      s = sda_line;
      scl = 1'b0;
   endtask : bitx
   // eight bits then the acknowledge slot
   task automatic byte_x(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bitx(tx[i], s);  // msb first
         rx[i] = s;
      end
      bitx(ack_in, s);
      ack = !s;
   endtask : byte_x
   // start or repeated start: data falls while clock high
   task automatic start_c;
      sda_drv = 1'b1;
      hp();
      scl = 1'b1;
      hp();
      sda_drv = 1'b0;
      hp();
      scl = 1'b0;
   endtask : start_c
   // stop: data rises while clock high
   task automatic stop_c;
      repeat (2) @(negedge core_clk);
      sda_drv = 1'b0;
      hp();
      scl = 1'b1;
      hp();
      sda_drv = 1'b1;
      hp();
   endtask : stop_c
   // address, two index bytes, two data bytes, stop
   task automatic wr(input logic [6:0] dev, input logic [15:0] idx, input logic [15:0] d, output logic ok);
      logic [7:0] rx;
      logic       a0, a1, a2, a3, a4;
      start_c();
      byte_x({dev, 1'b0}, 1'b1, rx, a0);
      byte_x(idx[15:8], 1'b1, rx, a1);
      byte_x(idx[7:0], 1'b1, rx, a2);
      byte_x(d[15:8], 1'b1, rx, a3);
      byte_x(d[7:0], 1'b1, rx, a4);
      stop_c();
      ok = a0 & a1 & a2 & a3 & a4;
   endtask : wr
   // index phase, repeated start, two bytes back
   task automatic rd(input logic [6:0] dev, input logic [15:0] idx, output logic [15:0] d, output logic ok);
      logic [7:0] rx;
      logic       a0, a1, a2, a3, n;
      start_c();
      byte_x({dev, 1'b0}, 1'b1, rx, a0);
      byte_x(idx[15:8], 1'b1, rx, a1);
      byte_x(idx[7:0], 1'b1, rx, a2);
      start_c();
      byte_x({dev, 1'b1}, 1'b1, rx, a3);
      byte_x(8'hFF, 1'b0, d[15:8], n);
      byte_x(8'hFF, 1'b1, d[7:0], n);  // left high to end the read
      stop_c();
      ok = a0 & a1 & a2 & a3;
   endtask : rd
endmodule : pllcfg_master
`default_nettype wire

// >>> bench/pllcfg_bench.sv
`timescale 1ns/100ps
`default_nettype none
module pllcfg_bench;
   localparam logic [6:0] DEV = 7'h56;  // fixed bits plus straps 1,0
   logic core_clk, reset_n, hard_reset_pin_n, addr_select_hi, addr_select_lo, scl, sda_drv, sda_line;
   logic sda_out, sda_oe, soft_hold_n, divider_align_n, vco_calibrate_en;
   logic stat_b_refclk_en, stat_b_refloss_en, stat_b_lock_en, stat_a_refclk_en, stat_a_refloss_en, stat_a_lock_en;
   logic [2:0]  loop_cap_sel, loop_res_sel, pump_current_sel;
   logic [13:0] ref_divider_value;
   logic [9:0]  feedback_div_wide;
   logic [7:0]  feedback_div_narrow;
   logic [1:0]  prescaler_second_sel, prescaler_first_sel;
   logic [15:0] ew [4];  // expected register words
   int          n_fail, n_checks, cyc;
   // pulled up line, low when either party pulls it
   assign sda_line = sda_drv & ~(sda_oe & ~sda_out);
   pllcfg_master m (.core_clk, .sda_line, .scl, .sda_drv);
   pllcfg_top DUT (.core_clk, .reset_n, .hard_reset_pin_n, .addr_select_hi, .addr_select_lo, .scl_in(scl),
      .sda_in(sda_line), .sda_out, .sda_oe, .loop_cap_sel, .loop_res_sel, .pump_current_sel, .ref_divider_value,
      .feedback_div_wide, .feedback_div_narrow, .stat_b_refclk_en, .stat_b_refloss_en, .stat_b_lock_en,
      .stat_a_refclk_en, .stat_a_refloss_en, .stat_a_lock_en, .soft_hold_n, .divider_align_n, .vco_calibrate_en,
      .prescaler_second_sel, .prescaler_first_sel);
   // clock source
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   // hang guard
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         n_fail++;
         give_verdict();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
      end
   endtask : check
   // every field output against the expected words
   task automatic t_fields;
      check({loop_cap_sel, loop_res_sel, pump_current_sel}, ew[0][9:1]);
      check(ref_divider_value, ew[1][15:2]);
      check(feedback_div_wide, {ew[1][1:0], ew[2][15:8]});
      check(feedback_div_narrow, ew[2][7:0]);
      check({stat_b_refclk_en, stat_b_refloss_en, stat_b_lock_en}, ew[3][12:10]);
      check({stat_a_refclk_en, stat_a_refloss_en, stat_a_lock_en}, ew[3][9:7]);
      check({soft_hold_n, divider_align_n, vco_calibrate_en}, ew[3][6:4]);
      check({prescaler_second_sel, prescaler_first_sel}, ew[3][3:0]);
   endtask : t_fields
   // read all four words, compare with the expected words
   task automatic t_readall;
      logic [15:0] d;
      logic        ok;
      for (int i = 0; i < 4; i++) begin
         m.rd(DEV, 16'(i), d, ok);
         check(ok, 1'b1);
         check(d, ew[i]);
      end
      t_fields();
   endtask : t_readall
   // back to back writes, bit zero of the loop word stays clear
   task automatic t_write_read;
      logic [15:0] w [4] = '{16'h03FF, 16'hA5C7, 16'h3C81, 16'h1FFA};  // reserved fields zero except bit 0 of the loop word
      logic        ok;
      for (int i = 0; i < 4; i++) begin
         m.wr(DEV, 16'(i), w[i], ok);
         check(ok, 1'b1);
      end
      ew = '{16'h03FE, 16'hA5C7, 16'h3C81, 16'h1FFA};
      t_readall();
      $display("write and read done");
   endtask : t_write_read
   // each legal prescaler code, hold and align released
   task automatic t_prescale;
      logic ok;
      for (int k = 0; k < 3; k++) begin
         ew[3] = 16'h0070 | 16'(k << 2) | 16'(k);
         m.wr(DEV, 16'h0003, ew[3], ok);
         check(ok, 1'b1);
         t_fields();
      end
      $display("prescaler codes done");
   endtask : t_prescale
   // index outside the map: store untouched, reads zero
   task automatic t_unmapped;
      logic [15:0] d;
      logic        ok;
      m.wr(DEV, 16'h0100, 16'hFFFF, ok);
      m.rd(DEV, 16'h0004, d, ok);
      check(d, 16'h0000);
      t_readall();
      $display("unmapped index done");
   endtask : t_unmapped
   // foreign addresses get no acknowledge and no write
   task automatic t_wrong_addr;
      logic [6:0] bad [3] = '{7'h54, 7'h57, 7'h16};
      logic       ok;
      for (int i = 0; i < 3; i++) begin
         m.wr(bad[i], 16'h0002, 16'h0000, ok);
         check(ok, 1'b0);
      end
      t_fields();
      $display("wrong address done");
   endtask : t_wrong_addr
   // hardware pin low: silent, store kept
   task automatic t_hard_pin;
      logic [15:0] d;
      logic        ok;
      hard_reset_pin_n = 1'b0;
      repeat (4) @(negedge core_clk);
      m.wr(DEV, 16'h0002, 16'h0000, ok);
      check(ok, 1'b0);
      hard_reset_pin_n = 1'b1;
      repeat (12) @(negedge core_clk);
      t_readall();
      $display("hardware pin done");
   endtask : t_hard_pin
   // slow master clock
   task automatic t_slow;
      logic [15:0] d;
      logic        ok;
      m.half = 20;
      m.rd(DEV, 16'h0001, d, ok);
      check(ok, 1'b1);
      check(d, ew[1]);
      m.half = 10;
      $display("slow master done");
   endtask : t_slow
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict
   // main sequence
   initial begin
      n_fail = 0;
      n_checks = 0;
      cyc = 0;
      ew = '{default: 16'h0000};
      reset_n = 1'b0;
      hard_reset_pin_n = 1'b1;
      addr_select_hi = 1'b1;
      addr_select_lo = 1'b0;
      repeat (8) @(negedge core_clk);
      reset_n = 1'b1;
      repeat (12) @(negedge core_clk);
      t_readall();  // reset words all zero
      $display("reset values done");
      t_write_read();
      t_prescale();
      t_unmapped();
      t_wrong_addr();
      t_hard_pin();
      t_slow();
      give_verdict();
   end
endmodule : pllcfg_bench
bind pllcfg_top pllcfg_checker chk (.core_clk, .reset_n, .hard_reset_pin_n, .scl_in, .sda_in, .sda_out, .sda_oe,
   .loop_cap_sel, .ref_divider_value, .feedback_div_narrow, .soft_hold_n, .divider_align_n);
`default_nettype wire
